// File: pkg/gpm_params.svh
// constants for the gpio port and pin function multiplexer
// assumes inclusion by gpm_pkg, the design modules and the port checker
`ifndef GPM_PARAMS_SVH
`define GPM_PARAMS_SVH
`define GPM_NUM_PORTS 18
`define GPM_PINS_PER_PORT 8
`define GPM_NUM_PINS 144
`define GPM_FUNC_W 6
`define GPM_ADDR_W 8
`define GPM_PORT_W 5
`define GPM_DATA_W 8
`define GPM_FMT_CMOS 2'h0
`define GPM_FMT_NCH 2'h1
`define GPM_FMT_PCH 2'h2
`define GPM_GUARD_OPEN_BIT 0
`define GPM_PFS_RESET 6'h00
`endif

// File: pkg/gpm_pkg.sv
// types shared by the gpio port and pin function multiplexer
// assumes gpm_params.svh is on the include path
`include "gpm_params.svh"
package gpm_pkg;
  typedef enum logic [4:0] {
    GPM_REG_DIR, GPM_REG_OUT, GPM_REG_IN, GPM_REG_MODE, GPM_REG_FMT_A, GPM_REG_FMT_B,
    GPM_REG_PULL, GPM_REG_DRIVE, GPM_REG_GUARD, GPM_REG_PFS, GPM_REG_CS_EN,
    GPM_REG_CS_LO, GPM_REG_CS_HI, GPM_REG_AOE_A, GPM_REG_AOE_B, GPM_REG_BCR_A,
    GPM_REG_BCR_B, GPM_REG_ENET
  } gpm_reg_e;

  typedef logic [`GPM_NUM_PORTS-1:0][`GPM_PINS_PER_PORT-1:0] gpm_port_t;

  typedef struct packed {
    gpm_port_t port_direction_reg;
    gpm_port_t port_output_value_reg;
    gpm_port_t port_mode_select_reg;
    gpm_port_t output_format_ctrl_a;
    gpm_port_t output_format_ctrl_b;
    gpm_port_t pullup_ctrl_reg;
    gpm_port_t drive_strength_reg;
    gpm_port_t sync_first;
    gpm_port_t port_input_value_reg;
    logic guard_open;
    logic [7:0] chip_select_output_enable;
    logic [7:0] chip_select_pin_sel_low;
    logic [7:0] chip_select_pin_sel_high;
    logic [7:0] address_output_enable_a;
    logic [7:0] address_output_enable_b;
    logic [7:0] ext_bus_pin_ctrl_a;
    logic [7:0] ext_bus_pin_ctrl_b;
    logic [7:0] ethernet_phy_mode_sel;
    logic [7:0] rdata;
    logic rvalid;
    logic rd_pfs;
  } gpm_state_s;

  typedef struct packed {
    logic [`GPM_NUM_PINS-1:0][`GPM_FUNC_W-1:0] code;
    logic [`GPM_FUNC_W-1:0] rdata;
  } gpm_mem_s;
endpackage

// File: logic/gpm_pfs_mem.sv
// per-pin function select storage, one word per pin
// assumes the caller gates writes with the write guard
`timescale 1ns/1ps
`include "gpm_params.svh"
module gpm_pfs_mem
  import gpm_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic we,
  input wire logic [`GPM_ADDR_W-1:0] waddr,
  input wire logic [`GPM_FUNC_W-1:0] wdata,
  input wire logic re,
  input wire logic [`GPM_ADDR_W-1:0] raddr,
  output logic [`GPM_FUNC_W-1:0] rdata,
  output logic [`GPM_NUM_PINS*`GPM_FUNC_W-1:0] codes
);
  gpm_mem_s s;
  gpm_mem_s next_s;

  always_comb begin
    next_s = s;
    if (we && (waddr < `GPM_ADDR_W'(`GPM_NUM_PINS))) begin
      next_s.code[waddr] = wdata;
    end
    if (re) begin
      next_s.rdata = (raddr < `GPM_ADDR_W'(`GPM_NUM_PINS)) ? s.code[raddr] : '0;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign rdata = s.rdata;
  assign codes = s.code;
endmodule

// File: logic/gpm_port.sv
// gpio ports with per-pin function multiplexer and external bus pin setup
// assumes pins and peripheral signals are synchronous to clk
//
// What this block does
// RULE_01: direction bit: 0 input, 1 output
// RULE_02: output value register drives general outputs
// RULE_03: input register reads present pin levels
// RULE_04: mode bit 0 general, 1 peripheral
// RULE_05: format a: cmos, n-open, p-open drain
// RULE_06: format b: cmos or n-open drain only
// RULE_07: pull-up bit switches input pull-up
// RULE_08: drive bit selects normal or high drive
// RULE_09: guard blocks function select writes
// RULE_10: one function select word per pin
// RULE_11: ports 0-9, A-G, J; pins 0-7
// RULE_12: eight chip-select outputs individually enabled
// RULE_13: two chip-select pin selects, 0-3, 4-7
// RULE_14: two address enables, two bus controls
// RULE_15: ethernet register selects phy mode
// RULE_16: software orders general output setup steps
// RULE_17: software orders peripheral assignment steps
// RULE_18: reset: inputs, no pull-up, guard closed
// RULE_19: pins pass two-stage synchroniser before read
`timescale 1ns/1ps
`include "gpm_params.svh"
module gpm_port
  import gpm_pkg::*;
#(
  parameter int NUM_PORTS = `GPM_NUM_PORTS,
  parameter int NUM_PINS = `GPM_NUM_PINS
)(
  input wire logic clk,
  input wire logic rst,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire gpm_reg_e reg_sel,
  input wire logic [`GPM_PORT_W-1:0] reg_port,
  input wire logic [2:0] reg_pin,
  input wire logic [`GPM_DATA_W-1:0] reg_wdata,
  output logic [`GPM_DATA_W-1:0] reg_rdata,
  output logic reg_rvalid,
  input wire logic [NUM_PINS-1:0] pin_in,
  output logic [NUM_PINS-1:0] pin_out,
  output logic [NUM_PINS-1:0] pin_oe,
  output logic [NUM_PINS-1:0] pin_pullup,
  output logic [NUM_PINS-1:0] pin_high_drive,
  input wire logic [NUM_PINS-1:0] periph_out,
  input wire logic [NUM_PINS-1:0] periph_oe,
  output logic [NUM_PINS-1:0] periph_in,
  output logic [NUM_PINS-1:0] pin_periph_mode,
  output logic [NUM_PINS*`GPM_FUNC_W-1:0] pin_func_sel,
  output logic [7:0] chip_select_output_enable,
  output logic [7:0] chip_select_pin_sel_low,
  output logic [7:0] chip_select_pin_sel_high,
  output logic [15:0] address_output_enable,
  output logic [15:0] ext_bus_pin_ctrl,
  output logic [7:0] ethernet_phy_mode_sel
);
  gpm_state_s s;
  gpm_state_s next_s;
  logic port_ok;
  logic pfs_we;
  logic pfs_re;
  logic [`GPM_ADDR_W-1:0] pfs_addr;
  logic [`GPM_FUNC_W-1:0] pfs_rdata;

  // port index 0..17 maps ports 0-9, A-G, J in that order
  assign port_ok = reg_port < `GPM_PORT_W'(NUM_PORTS); // RULE_11
  assign pfs_addr = {reg_port, reg_pin}; // RULE_10
  assign pfs_we = reg_wr && (reg_sel == GPM_REG_PFS) && port_ok && s.guard_open; // RULE_09
  assign pfs_re = reg_rd && (reg_sel == GPM_REG_PFS) && port_ok;

  gpm_pfs_mem u_pfs (
    .clk(clk),
    .rst(rst),
    .we(pfs_we),
    .waddr(pfs_addr),
    .wdata(reg_wdata[`GPM_FUNC_W-1:0]),
    .re(pfs_re),
    .raddr(pfs_addr),
    .rdata(pfs_rdata),
    .codes(pin_func_sel)
  );

  function automatic logic [7:0] read_word(input gpm_state_s st, input gpm_reg_e sel,
                                           input logic [`GPM_PORT_W-1:0] pt,
                                           input logic ok);
    logic [7:0] w;
    w = '0;
    case (sel)
      GPM_REG_DIR: w = ok ? st.port_direction_reg[pt] : '0;
      GPM_REG_OUT: w = ok ? st.port_output_value_reg[pt] : '0;
      GPM_REG_IN: w = ok ? st.port_input_value_reg[pt] : '0; // RULE_03
      GPM_REG_MODE: w = ok ? st.port_mode_select_reg[pt] : '0;
      GPM_REG_FMT_A: w = ok ? st.output_format_ctrl_a[pt] : '0;
      GPM_REG_FMT_B: w = ok ? st.output_format_ctrl_b[pt] : '0;
      GPM_REG_PULL: w = ok ? st.pullup_ctrl_reg[pt] : '0;
      GPM_REG_DRIVE: w = ok ? st.drive_strength_reg[pt] : '0;
      GPM_REG_GUARD: w = {7'h00, st.guard_open};
      GPM_REG_CS_EN: w = st.chip_select_output_enable;
      GPM_REG_CS_LO: w = st.chip_select_pin_sel_low;
      GPM_REG_CS_HI: w = st.chip_select_pin_sel_high;
      GPM_REG_AOE_A: w = st.address_output_enable_a;
      GPM_REG_AOE_B: w = st.address_output_enable_b;
      GPM_REG_BCR_A: w = st.ext_bus_pin_ctrl_a;
      GPM_REG_BCR_B: w = st.ext_bus_pin_ctrl_b;
      GPM_REG_ENET: w = st.ethernet_phy_mode_sel;
      default: w = '0;
    endcase
    return w;
  endfunction

  always_comb begin
    next_s = s;
    // rd_pfs holds between reads so the function word stays on reg_rdata
    next_s.rvalid = 1'b0;
    next_s.sync_first = pin_in; // RULE_19
    next_s.port_input_value_reg = s.sync_first; // RULE_19
    if (reg_wr) begin
      case (reg_sel)
        GPM_REG_DIR: if (port_ok) next_s.port_direction_reg[reg_port] = reg_wdata; // RULE_01
        GPM_REG_OUT: if (port_ok) next_s.port_output_value_reg[reg_port] = reg_wdata; // RULE_02
        GPM_REG_MODE: if (port_ok) next_s.port_mode_select_reg[reg_port] = reg_wdata; // RULE_04
        GPM_REG_FMT_A: if (port_ok) next_s.output_format_ctrl_a[reg_port] = reg_wdata; // RULE_05
        // only the low bit of each pin pair exists in format b
        GPM_REG_FMT_B: if (port_ok) next_s.output_format_ctrl_b[reg_port] = reg_wdata & 8'h55; // RULE_06
        GPM_REG_PULL: if (port_ok) next_s.pullup_ctrl_reg[reg_port] = reg_wdata; // RULE_07
        GPM_REG_DRIVE: if (port_ok) next_s.drive_strength_reg[reg_port] = reg_wdata; // RULE_08
        GPM_REG_GUARD: next_s.guard_open = reg_wdata[`GPM_GUARD_OPEN_BIT]; // RULE_09
        GPM_REG_CS_EN: next_s.chip_select_output_enable = reg_wdata; // RULE_12
        GPM_REG_CS_LO: next_s.chip_select_pin_sel_low = reg_wdata; // RULE_13
        GPM_REG_CS_HI: next_s.chip_select_pin_sel_high = reg_wdata; // RULE_13
        GPM_REG_AOE_A: next_s.address_output_enable_a = reg_wdata; // RULE_14
        GPM_REG_AOE_B: next_s.address_output_enable_b = reg_wdata; // RULE_14
        GPM_REG_BCR_A: next_s.ext_bus_pin_ctrl_a = reg_wdata; // RULE_14
        GPM_REG_BCR_B: next_s.ext_bus_pin_ctrl_b = reg_wdata; // RULE_14
        GPM_REG_ENET: next_s.ethernet_phy_mode_sel = reg_wdata; // RULE_15
        default: next_s.rdata = s.rdata;
      endcase
    end
    if (reg_rd) begin
      next_s.rvalid = 1'b1;
      next_s.rd_pfs = (reg_sel == GPM_REG_PFS);
      next_s.rdata = read_word(s, reg_sel, reg_port, port_ok);
    end
  end

  // all-zero reset: inputs, general mode, pull-ups off, guard closed
  always_ff @(posedge clk) begin
    if (rst) begin
      s <= '0; // RULE_18
    end else begin
      s <= next_s;
    end
  end

  assign reg_rvalid = s.rvalid;
  assign reg_rdata = s.rd_pfs ? {2'h0, pfs_rdata} : s.rdata;

  for (genvar i = 0; i < NUM_PINS; i++) begin : g_pin
    localparam int P = i / `GPM_PINS_PER_PORT;
    localparam int B = i % `GPM_PINS_PER_PORT;
    logic periph;
    logic drv_val;
    logic drv_en;
    logic [1:0] fmt;
    logic o_val;
    logic o_en;
    assign periph = s.port_mode_select_reg[P][B]; // RULE_04
    assign drv_val = periph ? periph_out[i] : s.port_output_value_reg[P][B]; // RULE_02
    assign drv_en = periph ? periph_oe[i] : s.port_direction_reg[P][B]; // RULE_01
    if (B < 4) begin : g_fmt_a
      assign fmt = s.output_format_ctrl_a[P][2*B+1 -: 2]; // RULE_05
    end else begin : g_fmt_b
      assign fmt = {1'b0, s.output_format_ctrl_b[P][2*(B-4)]}; // RULE_06
    end
    always_comb begin
      case (fmt)
        `GPM_FMT_NCH: begin
          o_val = 1'b0;
          o_en = drv_en & ~drv_val;
        end
        `GPM_FMT_PCH: begin
          o_val = 1'b1;
          o_en = drv_en & drv_val;
        end
        default: begin
          o_val = drv_val;
          o_en = drv_en;
        end
      endcase
    end
    assign pin_out[i] = o_val; // RULE_05
    assign pin_oe[i] = o_en; // RULE_05
    assign pin_pullup[i] = s.pullup_ctrl_reg[P][B] & ~drv_en; // RULE_07
    assign pin_high_drive[i] = s.drive_strength_reg[P][B]; // RULE_08
    assign periph_in[i] = s.port_input_value_reg[P][B];
    assign pin_periph_mode[i] = periph;
  end

  assign chip_select_output_enable = s.chip_select_output_enable; // RULE_12
  assign chip_select_pin_sel_low = s.chip_select_pin_sel_low;
  assign chip_select_pin_sel_high = s.chip_select_pin_sel_high;
  assign address_output_enable = {s.address_output_enable_b, s.address_output_enable_a};
  assign ext_bus_pin_ctrl = {s.ext_bus_pin_ctrl_b, s.ext_bus_pin_ctrl_a};
  assign ethernet_phy_mode_sel = s.ethernet_phy_mode_sel;
endmodule

// File: testbench/gpm_port_chk.sv
// assertions on the gpio port block ports
// assumes a bind from the bench top
`timescale 1ns/1ps
`include "gpm_params.svh"
module gpm_port_chk #(
  parameter int NUM_PINS = 144
)(
  input wire logic clk,
  input wire logic rst,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic reg_rvalid,
  input wire logic [NUM_PINS-1:0] pin_in,
  input wire logic [NUM_PINS-1:0] pin_oe,
  input wire logic [NUM_PINS-1:0] pin_pullup,
  input wire logic [NUM_PINS-1:0] periph_oe,
  input wire logic [NUM_PINS-1:0] periph_in,
  input wire logic [NUM_PINS-1:0] pin_periph_mode,
  input wire logic [NUM_PINS*`GPM_FUNC_W-1:0] pin_func_sel,
  input wire logic [7:0] chip_select_output_enable,
  input wire logic [7:0] ethernet_phy_mode_sel
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  sequence rd_answer;
    ##1 reg_rvalid;
  endsequence
  read_answer_a: assert property (reg_rd |-> rd_answer)
    else $error("read not answered");
  rvalid_single_a: assert property (!reg_rd |=> !reg_rvalid)
    else $error("answer without read");
  rdata_hold_a: assert property (!reg_rd |=> $stable(reg_rdata))
    else $error("read data moved");
  sync_two_a: assert property (!$past(rst) && !$past(rst, 2) |-> periph_in == $past(pin_in, 2))
    else $error("pin level latency wrong");
  periph_gate_a: assert property ((pin_periph_mode & ~periph_oe & pin_oe) == '0)
    else $error("peripheral pin driven");
  pullup_off_a: assert property ((pin_pullup & pin_oe) == '0)
    else $error("pull-up on driven pin");
  reset_state_a: assert property ($past(rst) |-> (pin_oe | pin_pullup | pin_periph_mode) == '0)
    else $error("pins not idle after reset");
  func_hold_a: assert property (!reg_wr |=> $stable(pin_func_sel))
    else $error("function select moved");
  cfg_hold_a: assert property (!reg_wr |=> $stable({chip_select_output_enable, ethernet_phy_mode_sel}))
    else $error("bus setup moved");
endmodule

// File: testbench/gpm_pin_model.sv
// pads and board around the gpio port block
// assumes the same clock as the block
`timescale 1ns/1ps
module gpm_pin_model #(
  parameter int NUM_PINS = 144
)(
  input wire logic clk,
  input wire logic [NUM_PINS-1:0] pin_out,
  input wire logic [NUM_PINS-1:0] pin_oe,
  input wire logic [NUM_PINS-1:0] pin_pullup,
  input wire logic [NUM_PINS-1:0] ext_val,
  input wire logic [NUM_PINS-1:0] ext_en,
  output logic [NUM_PINS-1:0] pin_in
);
  logic flip = 1'b0;
  // a floating pin keeps changing so a stale level is never read
  always @(posedge clk) flip <= ~flip;
  always_comb begin
    for (int i = 0; i < NUM_PINS; i++) begin
      if (pin_oe[i]) pin_in[i] = pin_out[i];
      else if (ext_en[i]) pin_in[i] = ext_val[i];
      else pin_in[i] = pin_pullup[i] | flip;
    end
  end
endmodule

// File: testbench/test_gpm_port.sv
// self-checking bench for the gpio port block
// assumes the pin model and checker are compiled first
`timescale 1ns/1ps
module test_gpm_port
  import gpm_pkg::*;
;
  typedef struct {gpm_reg_e sel; logic [4:0] port; logic [7:0] wd; logic [7:0] rd;} gpm_row_s;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  gpm_reg_e reg_sel = GPM_REG_DIR;
  logic [4:0] reg_port = 5'h00;
  logic [2:0] reg_pin = 3'h0;
  logic [7:0] reg_wdata = 8'h00, reg_rdata, chip_select_output_enable, ethernet_phy_mode_sel;
  logic [7:0] chip_select_pin_sel_low, chip_select_pin_sel_high;
  logic [15:0] address_output_enable, ext_bus_pin_ctrl;
  logic reg_rvalid;
  logic [143:0] pin_in, pin_out, pin_oe, pin_pullup, pin_high_drive, periph_in, pin_periph_mode;
  logic [143:0] periph_out = '0, periph_oe = '0, ext_val = '0, ext_en = '0;
  logic [863:0] pin_func_sel;
  int num_errors = 0;
  int checks_done = 0;
  int cycles = 0;
  gpm_row_s rows [16] = '{
    '{GPM_REG_DIR, 5'h00, 8'hA5, 8'hA5},
    '{GPM_REG_OUT, 5'h11, 8'h3C, 8'h3C},
    '{GPM_REG_MODE, 5'h10, 8'h81, 8'h81},
    '{GPM_REG_FMT_A, 5'h09, 8'hE4, 8'hE4},
    '{GPM_REG_FMT_B, 5'h09, 8'hFF, 8'h55},
    '{GPM_REG_PULL, 5'h03, 8'hC3, 8'hC3},
    '{GPM_REG_DRIVE, 5'h03, 8'h5A, 8'h5A},
    '{GPM_REG_DIR, 5'h12, 8'hFF, 8'h00},
    '{GPM_REG_CS_EN, 5'h00, 8'hA5, 8'hA5},
    '{GPM_REG_CS_LO, 5'h00, 8'h1B, 8'h1B},
    '{GPM_REG_CS_HI, 5'h00, 8'hE4, 8'hE4},
    '{GPM_REG_AOE_A, 5'h00, 8'h0F, 8'h0F},
    '{GPM_REG_AOE_B, 5'h00, 8'hF0, 8'hF0},
    '{GPM_REG_BCR_A, 5'h00, 8'h33, 8'h33},
    '{GPM_REG_BCR_B, 5'h00, 8'hCC, 8'hCC},
    '{GPM_REG_ENET, 5'h00, 8'h10, 8'h10}};
  gpm_port u_gpm_port (.clk, .rst, .reg_wr, .reg_rd, .reg_sel, .reg_port, .reg_pin, .reg_wdata,
    .reg_rdata, .reg_rvalid, .pin_in, .pin_out, .pin_oe, .pin_pullup, .pin_high_drive,
    .periph_out, .periph_oe, .periph_in, .pin_periph_mode, .pin_func_sel,
    .chip_select_output_enable, .chip_select_pin_sel_low, .chip_select_pin_sel_high,
    .address_output_enable, .ext_bus_pin_ctrl, .ethernet_phy_mode_sel);
  gpm_pin_model u_gpm_pin_model (.clk, .pin_out, .pin_oe, .pin_pullup, .ext_val, .ext_en, .pin_in);
  initial forever #25 clk = ~clk;
  task automatic check(input string what, input logic [143:0] exp, input logic [143:0] got);
    checks_done++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic access(input logic wr, input gpm_reg_e sel, input logic [4:0] port,
    input logic [2:0] pin, input logic [7:0] data);
    @(posedge clk);
    reg_wr <= wr;
    reg_rd <= ~wr;
    reg_sel <= sel;
    reg_port <= port;
    reg_pin <= pin;
    reg_wdata <= data;
    @(posedge clk);
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    #1;
  endtask
  task automatic rd_check(input gpm_reg_e sel, input logic [4:0] port, input logic [2:0] pin,
    input logic [7:0] exp);
    access(1'b0, sel, port, pin, 8'h00);
    check("rvalid", 1'b1, reg_rvalid);
    check("rdata", exp, reg_rdata);
  endtask
  task automatic conclude();
    if (num_errors == 0 && checks_done > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 4000) begin
      num_errors++;
      conclude();
    end
  end
  initial begin
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    #1;
    check("reset", '0, pin_oe | pin_pullup | pin_periph_mode | {143'h0, |pin_func_sel});
    rd_check(GPM_REG_GUARD, 5'h00, 3'h0, 8'h00);
    foreach (rows[i]) begin
      access(1'b1, rows[i].sel, rows[i].port, 3'h0, rows[i].wd);
      rd_check(rows[i].sel, rows[i].port, 3'h0, rows[i].rd);
    end
    check("cs", 24'hE41BA5, {chip_select_pin_sel_high, chip_select_pin_sel_low,
      chip_select_output_enable});
    check("bus", 32'hCC33F00F, {ext_bus_pin_ctrl, address_output_enable});
    check("enet", 8'h10, ethernet_phy_mode_sel);
    access(1'b1, GPM_REG_FMT_A, 5'h02, 3'h0, 8'h40);
    access(1'b1, GPM_REG_PULL, 5'h02, 3'h0, 8'h08);
    check("pullup", 1'b1, pin_pullup[19]);
    access(1'b1, GPM_REG_DRIVE, 5'h02, 3'h0, 8'h08);
    access(1'b1, GPM_REG_OUT, 5'h02, 3'h0, 8'h08);
    access(1'b1, GPM_REG_DIR, 5'h02, 3'h0, 8'h08);
    access(1'b1, GPM_REG_MODE, 5'h02, 3'h0, 8'h00);
    check("drive", 1'b1, pin_high_drive[19]);
    check("n release", 2'b00, {pin_oe[19], pin_out[19]});
    access(1'b1, GPM_REG_OUT, 5'h02, 3'h0, 8'h00);
    check("n sink", 3'b100, {pin_oe[19], pin_out[19], pin_pullup[19]});
    access(1'b1, GPM_REG_FMT_A, 5'h02, 3'h0, 8'h80);
    check("p release", 2'b01, {pin_oe[19], pin_out[19]});
    access(1'b1, GPM_REG_FMT_A, 5'h02, 3'h0, 8'h00);
    access(1'b1, GPM_REG_FMT_B, 5'h02, 3'h0, 8'h01);
    access(1'b1, GPM_REG_OUT, 5'h02, 3'h0, 8'h18);
    access(1'b1, GPM_REG_DIR, 5'h02, 3'h0, 8'h18);
    check("cmos n", 4'b1100, {pin_oe[19], pin_out[19], pin_oe[20], pin_out[20]});
    @(posedge clk);
    ext_en[15:8] <= 8'hFF;
    ext_val[15:8] <= 8'h5A;
    ext_en[143:136] <= 8'hFF;
    ext_val[143:136] <= 8'hC3;
    repeat (3) @(posedge clk);
    rd_check(GPM_REG_IN, 5'h01, 3'h0, 8'h5A);
    rd_check(GPM_REG_IN, 5'h11, 3'h0, 8'hC3);
    check("sync", 8'h5A, periph_in[15:8]);
    access(1'b1, GPM_REG_PFS, 5'h01, 3'h2, 8'h2A);
    rd_check(GPM_REG_PFS, 5'h01, 3'h2, 8'h00);
    access(1'b1, GPM_REG_GUARD, 5'h00, 3'h0, 8'h01);
    access(1'b1, GPM_REG_PFS, 5'h01, 3'h2, 8'h2A);
    access(1'b1, GPM_REG_GUARD, 5'h00, 3'h0, 8'h00);
    access(1'b1, GPM_REG_PFS, 5'h01, 3'h2, 8'h15);
    rd_check(GPM_REG_PFS, 5'h01, 3'h2, 8'h2A);
    check("func", 6'h2A, pin_func_sel[60+:6]);
    @(posedge clk);
    ext_en[10] <= 1'b0;
    periph_oe[10] <= 1'b1;
    periph_out[10] <= 1'b1;
    access(1'b1, GPM_REG_MODE, 5'h01, 3'h0, 8'h04);
    check("periph", 3'b111, {pin_periph_mode[10], pin_oe[10], pin_out[10]});
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    #1;
    check("reset again", '0, pin_oe | pin_pullup | pin_periph_mode | {143'h0, |pin_func_sel});
    check("cfg reset", '0, {ext_bus_pin_ctrl, chip_select_output_enable});
    rd_check(GPM_REG_GUARD, 5'h00, 3'h0, 8'h00);
    conclude();
  end
endmodule
bind gpm_port gpm_port_chk #(.NUM_PINS(NUM_PINS)) u_gpm_port_chk (.clk, .rst, .reg_wr, .reg_rd,
  .reg_rdata, .reg_rvalid, .pin_in, .pin_oe, .pin_pullup, .periph_oe, .periph_in,
  .pin_periph_mode, .pin_func_sel, .chip_select_output_enable, .ethernet_phy_mode_sel);
